// >>> rtl/sras_pkg.sv
// Shared constants, types and register map of the serial register-access port.
package sras_pkg;

  // Widths of bytes, address parts, results and counters.
  localparam int DATA_W = 8;
  localparam int URA_W  = 3;
  localparam int LRA_W  = 4;
  localparam int ADDR_W = URA_W + LRA_W;
  localparam int RES_W  = 16;
  localparam int OFF_W  = 3;
  localparam int BIT_W  = 3;
  localparam int LEFT_W = 2;

  // Register offsets within the full register address.
  localparam logic [ADDR_W-1:0] ADDR_STREAM_CONTROL = 7'h03;
  localparam logic [ADDR_W-1:0] ADDR_RESULT_HIGH    = 7'h1a;
  localparam logic [ADDR_W-1:0] ADDR_RESULT_LOW     = 7'h1b;

  // Instruction codes of the upper-address setup transaction.
  localparam logic [DATA_W-1:0] INST_URA_WRITE = 8'h10;
  localparam logic [DATA_W-1:0] INST_URA_READ  = 8'h90;

  // Transfer size code that selects streaming in a data-access instruction.
  localparam logic [LEFT_W-1:0] SIZE_STREAM = 2'h3;

  // Index of the last bit of a byte.
  localparam logic [BIT_W-1:0] BIT_LAST = 3'h7;

  // Reset values and result extremes.
  localparam logic [DATA_W-1:0] STREAM_CONTROL_RESET = 8'h00;
  localparam logic [URA_W-1:0]  URA_RESET            = 3'h0;
  localparam logic [RES_W-1:0]  RESULT_RESET         = 16'h0000;
  localparam logic [RES_W-1:0]  RESULT_MAX           = 16'h7fff;
  localparam logic [RES_W-1:0]  RESULT_MIN           = 16'h8000;

  // Depth of the result queue.
  localparam int FIFO_DEPTH = 4;

  // Stream control register layout.
  typedef struct packed {
    logic             stream_type_select;
    logic [3:0]       reserved;
    logic [OFF_W-1:0] stream_window_length;
  } sras_stream_control_s;

  // Data-access instruction byte layout.
  typedef struct packed {
    logic              read_write_select;
    logic [LEFT_W-1:0] size;
    logic              reserved;
    logic [LRA_W-1:0]  lower_register_address;
  } sras_data_inst_s;

  // Byte-level sequencing states of a frame.
  typedef enum logic [3:0] {
    ST_INST   = 4'b0001,
    ST_UAB_WR = 4'b0010,
    ST_UAB_RD = 4'b0100,
    ST_DATA   = 4'b1000
  } sras_state_e;

endpackage

// >>> rtl/sras_sync2.sv
// Two-flop level synchroniser into the domain of clk.
module sras_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  // The first stage is read by the second stage only.
  always_ff @(posedge clk) begin
    meta_q <= d;
    q      <= meta_q;
  end

endmodule

// >>> rtl/sras_fifo.sv
// Single-clock FIFO with valid and ready on both sides.
module sras_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [AW:0]   CNT_FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  // Full and empty come straight from the fill count.
  assign in_ready  = (cnt_q != CNT_FULL);
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage is written only on an accepted push.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers wrap at the configured depth.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == PTR_LAST) ? '0 : wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= (rd_q == PTR_LAST) ? '0 : rd_q + AW'(1);
      end
    end
  end

  // Fill count follows pushes and pops.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else if (push && !pop) begin
      cnt_q <= cnt_q + (AW + 1)'(1);
    end else if (pop && !push) begin
      cnt_q <= cnt_q - (AW + 1)'(1);
    end
  end

endmodule

// >>> rtl/sras_top.sv
// Serial register-access port with upper-address setup, streaming and result readback.
module sras_top
  import sras_pkg::*;
#(
  parameter int RAW_W = 20
) (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic [RAW_W-1:0] raw_data,
  input  wire logic             raw_valid,
  output logic                  raw_ready,
  input  wire logic             sclk,
  input  wire logic             chip_select_n,
  input  wire logic             mosi,
  output logic                  miso,
  output logic                  miso_oe
);

  // Converter clock domain signals.
  logic [RES_W-1:0]     sat_data;
  logic                 fifo_valid;
  logic [RES_W-1:0]     fifo_data;
  logic                 send;
  logic                 req_q;
  logic [RES_W-1:0]     data_q;
  logic                 rst_req_q;
  logic [1:0]           back_m;
  logic                 ack_m;
  logic                 rack_m;

  // Link clock domain signals.
  logic [1:0]           fwd_s;
  logic                 req_s;
  logic                 rst_s;
  logic                 ack_q;
  logic                 rack_q;
  logic [RES_W-1:0]     result_s_q;
  logic [URA_W-1:0]     ura_q;
  sras_stream_control_s ctrl_q;
  sras_state_e          state_q;
  logic [BIT_W-1:0]     bit_q;
  logic [DATA_W-2:0]    rx_q;
  logic                 rd_q;
  logic                 stream_q;
  logic [LEFT_W-1:0]    left_q;
  logic [ADDR_W-1:0]    addr_q;
  logic [ADDR_W-1:0]    win_start_q;
  logic [OFF_W-1:0]     win_off_q;
  logic [DATA_W-1:0]    tx_q;
  logic [DATA_W-1:0]    snap_q;
  logic                 snap_vld_q;
  logic                 miso_q;
  logic                 oe_q;

  // Decoded values of the byte under way.
  logic [DATA_W-1:0]    byte_w;
  logic                 byte_end;
  sras_data_inst_s      inst;
  logic [ADDR_W-1:0]    inst_addr;
  logic                 wrap;
  logic [ADDR_W-1:0]    adv_addr;
  logic [OFF_W-1:0]     adv_off;
  logic                 last_byte;
  logic                 rd_phase;

  // Clamp a wide signed sample to the result range.
  function automatic logic [RES_W-1:0] sat_result(input logic [RAW_W-1:0] x);
    logic [RES_W-1:0] v;
    v = x[RES_W-1:0];
    if (!(&x[RAW_W-1:RES_W-1]) && (|x[RAW_W-1:RES_W-1])) begin
      v = x[RAW_W-1] ? RESULT_MIN : RESULT_MAX;
    end
    return v;
  endfunction

  // Read value of a register address; unmapped addresses read as zero.
  function automatic logic [DATA_W-1:0] rd_byte(input logic [ADDR_W-1:0] addr);
    logic [DATA_W-1:0] v;
    v = '0;
    case (addr)
      ADDR_STREAM_CONTROL: begin
        v = {ctrl_q.stream_type_select, 4'h0, ctrl_q.stream_window_length};
      end
      ADDR_RESULT_HIGH: begin
        v = result_s_q[RES_W-1:DATA_W];
      end
      ADDR_RESULT_LOW: begin
        v = snap_vld_q ? snap_q : result_s_q[DATA_W-1:0];
      end
      default: begin
        v = '0;
      end
    endcase
    return v;
  endfunction

  // ---------------- Converter clock domain ----------------

  assign sat_data = sat_result(raw_data);

  // Result queue between the converter and the link crossing.
  sras_fifo #(
    .WIDTH (RES_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (mclk),
    .nrst      (nrst),
    .in_valid  (raw_valid),
    .in_ready  (raw_ready),
    .in_data   (sat_data),
    .out_valid (fifo_valid),
    .out_ready (send),
    .out_data  (fifo_data)
  );

  // Acknowledges from the link domain.
  sras_sync2 #(
    .WIDTH (2)
  ) u_sync_back (
    .clk (mclk),
    .d   ({rack_q, ack_q}),
    .q   (back_m)
  );

  assign ack_m  = back_m[0];
  assign rack_m = back_m[1];

  // A new result leaves only when the previous one was taken.
  assign send = fifo_valid && (req_q == ack_m) && !rst_req_q;

  // hold the 16-bit code stable while the request toggles.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      req_q  <= 1'b0;
      data_q <= RESULT_RESET;
    end else if (send) begin
      req_q  <= ~req_q;
      data_q <= fifo_data;
    end
  end

  // Reset request held until the link domain confirms it.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rst_req_q <= 1'b1;
    end else if (rack_m) begin
      rst_req_q <= 1'b0;
    end
  end

  // ---------------- Link clock domain ----------------

  // Request and reset levels into the link domain.
  sras_sync2 #(
    .WIDTH (2)
  ) u_sync_fwd (
    .clk (sclk),
    .d   ({rst_req_q, req_q}),
    .q   (fwd_s)
  );

  assign req_s = fwd_s[0];
  assign rst_s = fwd_s[1];

  // Result copy on each new request, acknowledged by toggle.
  always_ff @(posedge sclk) begin
    if (rst_s) begin
      ack_q      <= 1'b0;
      result_s_q <= RESULT_RESET;
    end else if (req_s != ack_q) begin
      ack_q      <= req_s;
      result_s_q <= data_q;
    end
  end

  // Reset acknowledge follows the synchronised reset level.
  always_ff @(posedge sclk) begin
    rack_q <= rst_s;
  end

  // Byte assembly and next-address decode.
  always_comb begin
    byte_w    = {rx_q, mosi};
    byte_end  = (bit_q == BIT_LAST) && !chip_select_n;
    inst      = sras_data_inst_s'(byte_w);
    inst_addr = {ura_q, inst.lower_register_address};
    // window ends at offset equal to the length field.
    wrap      = stream_q && ctrl_q.stream_type_select && (win_off_q == ctrl_q.stream_window_length);
    adv_addr  = wrap ? win_start_q : addr_q + ADDR_W'(1);
    adv_off   = wrap ? '0 : win_off_q + OFF_W'(1);
    last_byte = !stream_q && (left_q == '0);
    rd_phase  = ((state_q == ST_DATA) && rd_q) || (state_q == ST_UAB_RD);
  end

  // Bit counter and receive shift; both restart with each frame.
  always_ff @(posedge sclk or posedge chip_select_n) begin
    if (chip_select_n) begin
      bit_q <= '0;
      rx_q  <= '0;
    end else begin
      bit_q <= bit_q + BIT_W'(1);
      rx_q  <= byte_w[DATA_W-2:0];
    end
  end

  // Byte sequencing of a frame.
  always_ff @(posedge sclk or posedge chip_select_n) begin
    if (chip_select_n) begin
      state_q  <= ST_INST;
      rd_q     <= 1'b0;
      stream_q <= 1'b0;
      left_q   <= '0;
    end else if (byte_end) begin
      case (state_q)
        ST_INST: begin
          if (byte_w == INST_URA_WRITE) begin
            state_q <= ST_UAB_WR;
          end else if (byte_w == INST_URA_READ) begin
            state_q <= ST_UAB_RD;
          end else begin
            state_q  <= ST_DATA;
            rd_q     <= inst.read_write_select;
            stream_q <= (inst.size == SIZE_STREAM);
            left_q   <= inst.size;
          end
        end
        ST_UAB_WR: begin
          state_q <= ST_INST;
        end
        ST_UAB_RD: begin
          state_q <= ST_INST;
        end
        ST_DATA: begin
          // stop after the sized count; streams run until chip select.
          if (last_byte) begin
            state_q <= ST_INST;
          end else if (!stream_q) begin
            left_q <= left_q - LEFT_W'(1);
          end
        end
        default: begin
          state_q <= ST_INST;
        end
      endcase
    end
  end

  // Address counter and window tracking.
  always_ff @(posedge sclk or posedge chip_select_n) begin
    if (chip_select_n) begin
      addr_q      <= '0;
      win_start_q <= '0;
      win_off_q   <= '0;
    end else if (byte_end) begin
      if ((state_q == ST_INST) && (byte_w != INST_URA_WRITE) && (byte_w != INST_URA_READ)) begin
        addr_q      <= inst_addr;
        win_start_q <= inst_addr;
        win_off_q   <= '0;
      end else if (state_q == ST_DATA) begin
        addr_q    <= adv_addr;
        win_off_q <= adv_off;
      end
    end
  end

  // Persistent configuration: upper address and stream control.
  always_ff @(posedge sclk) begin
    if (rst_s) begin
      ura_q  <= URA_RESET;
      ctrl_q <= sras_stream_control_s'(STREAM_CONTROL_RESET);
    end else if (byte_end) begin
      if (state_q == ST_UAB_WR) begin
        // keep the low three bits only.
        ura_q <= byte_w[URA_W-1:0];
      end else if ((state_q == ST_DATA) && !rd_q && (addr_q == ADDR_STREAM_CONTROL)) begin
        // stream type and window length from a write to 0x03.
        ctrl_q.stream_type_select   <= byte_w[DATA_W-1];
        ctrl_q.stream_window_length <= byte_w[OFF_W-1:0];
        ctrl_q.reserved             <= '0;
      end
    end
  end

  // Transmit byte load at the end of the previous byte.
  always_ff @(posedge sclk or posedge chip_select_n) begin
    if (chip_select_n) begin
      tx_q <= '0;
    end else if (byte_end) begin
      if ((state_q == ST_INST) && (byte_w == INST_URA_READ)) begin
        // upper address with zero above it.
        tx_q <= DATA_W'(ura_q);
      end else if ((state_q == ST_INST) && (byte_w != INST_URA_WRITE) && inst.read_write_select) begin
        tx_q <= rd_byte(inst_addr);
      end else if ((state_q == ST_DATA) && rd_q && !last_byte) begin
        tx_q <= rd_byte(adv_addr);
      end else begin
        tx_q <= '0;
      end
    end
  end

  // low byte is frozen when the high byte is loaded.
  always_ff @(posedge sclk or posedge chip_select_n) begin
    if (chip_select_n) begin
      snap_q     <= '0;
      snap_vld_q <= 1'b0;
    end else if (byte_end) begin
      if ((state_q == ST_INST) && inst.read_write_select && (inst_addr == ADDR_RESULT_HIGH)) begin
        snap_q     <= result_s_q[DATA_W-1:0];
        snap_vld_q <= 1'b1;
      end else if ((state_q == ST_DATA) && rd_q && !last_byte && (adv_addr == ADDR_RESULT_HIGH)) begin
        snap_q     <= result_s_q[DATA_W-1:0];
        snap_vld_q <= 1'b1;
      end
    end
  end

  // Serial output changes on the falling edge, most significant bit first.
  always_ff @(negedge sclk or posedge chip_select_n) begin
    if (chip_select_n) begin
      miso_q <= 1'b0;
      oe_q   <= 1'b0;
    end else begin
      miso_q <= rd_phase ? tx_q[BIT_LAST - bit_q] : 1'b0;
      oe_q   <= rd_phase;
    end
  end

  // Pin drive comes from flops only.
  assign miso    = miso_q;
  assign miso_oe = oe_q;

endmodule

// >>> verif/sras_top_asserts.sv
// Port checker of the serial register-access port, with its bind.
module sras_top_checker
  import sras_pkg::*;
#(
  parameter int RAW_W = 20
) (
  input wire logic             mclk,
  input wire logic             nrst,
  input wire logic [RAW_W-1:0] raw_data,
  input wire logic             raw_valid,
  input wire logic             raw_ready,
  input wire logic             sclk,
  input wire logic             chip_select_n,
  input wire logic             mosi,
  input wire logic             miso,
  input wire logic             miso_oe
);
  logic [7:0] cnt_q;
  logic [7:0] sh_q;

  // Counts link rises since select fell and keeps the last eight bits in.
  always_ff @(posedge sclk or posedge chip_select_n) begin
    if (chip_select_n) begin
      cnt_q <= 8'h00;
      sh_q  <= 8'h00;
    end else begin
      cnt_q <= (cnt_q == 8'hff) ? cnt_q : cnt_q + 8'h01;
      sh_q  <= {sh_q[6:0], mosi};
    end
  end

  // The first instruction of a frame has just been shifted in.
  sequence s_setup_instr;
    cnt_q == 8'h08 && sh_q == INST_URA_WRITE;
  endsequence
  sequence s_ura_read;
    cnt_q == 8'h08 && sh_q == INST_URA_READ;
  endsequence
  sequence s_read_instr;
    cnt_q == 8'h08 && sh_q[7];
  endsequence

  chk_cs_idle_quiet: assert property (
    @(posedge mclk) disable iff (!nrst) chip_select_n |-> !miso_oe)
    else $error("output enabled while deselected");
  chk_miso_low_idle: assert property (
    @(posedge mclk) disable iff (!nrst) !miso_oe |-> !miso)
    else $error("data line high while not driven");
  chk_ready_fall_cause: assert property (
    @(posedge mclk) disable iff (!nrst) $fell(raw_ready) |-> $past(raw_valid))
    else $error("ready dropped without an accepted sample");
  chk_oe_on_fall: assert property (
    @(posedge mclk) disable iff (!nrst || chip_select_n) $rose(miso_oe) |-> !sclk)
    else $error("output enable rose outside a low link clock");
  chk_instr_no_drive: assert property (
    @(negedge sclk) disable iff (chip_select_n) cnt_q < 8'h08 |-> !miso_oe)
    else $error("driven during the instruction byte");
  chk_setup_no_drive: assert property (
    @(negedge sclk) disable iff (chip_select_n) s_setup_instr |=> !miso_oe [*8])
    else $error("driven during the upper address write");
  chk_read_drives: assert property (
    @(negedge sclk) disable iff (chip_select_n) s_read_instr |=> miso_oe [*8])
    else $error("read byte not driven");
  chk_ura_high_zero: assert property (
    @(negedge sclk) disable iff (chip_select_n) s_ura_read |=> !miso [*5])
    else $error("upper address high bits not zero");
endmodule

bind sras_top sras_top_checker #(.RAW_W(RAW_W)) u_chk (
  .mclk(mclk), .nrst(nrst), .raw_data(raw_data), .raw_valid(raw_valid), .raw_ready(raw_ready),
  .sclk(sclk), .chip_select_n(chip_select_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe)
);

// >>> verif/sras_host.sv
// Serial master model that runs frames on the link.
module sras_host (
  output logic       sclk,
  output logic       chip_select_n,
  output logic       mosi,
  input  wire logic  miso,
  output logic [7:0] rx_q
);
  timeunit 1ns;
  timeprecision 1ps;
  event got;

  // The link clock rests low and select rests high between frames.
  // Select rises a moment after time zero, so the frame logic sees a clean clearing edge.
  initial begin
    sclk = 1'b0;
    mosi = 1'b0;
    rx_q = 8'h00;
    #1;
    chip_select_n = 1'b1;
  end

  // Opens a frame at a phase unrelated to the converter clock.
  task automatic start();
    #37;
    chip_select_n = 1'b0;
    #80;
  endtask

  // Select ends frames.
  // The released data line shows the inverse of its last bit.
  task automatic stop();
    #80;
    chip_select_n = 1'b1;
    mosi = ~mosi;
    #200;
  endtask

  // Shifts a byte out first bit high and samples the answer at each rise.
  task automatic xfer(input logic [7:0] tx, input bit chk);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #80;
      sclk = 1'b1;
      rx_q = {rx_q[6:0], miso};
      #80;
      sclk = 1'b0;
    end
    if (chk) begin
      -> got;
    end
  endtask
endmodule

// >>> verif/spi_register_access_streaming_bench.sv
// Self-checking bench for the serial register-access port.
module spi_register_access_streaming_bench;
  import sras_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int    RAW_W = 20;
  logic             mclk;
  logic             nrst;
  logic             raw_valid;
  logic             raw_ready;
  logic [RAW_W-1:0] raw_data;
  logic             sclk;
  logic             chip_select_n;
  logic             mosi;
  logic             miso;
  logic [7:0]       rx_q;
  logic [15:0]      res;
  logic [31:0]      lfsr_q;
  logic [7:0]       exp_q[$];
  int               err_count;
  int               total_checks;
  logic [RAW_W-1:0] tbl[6] = '{20'h7_ffff, 20'h8_0000, 20'h0_8000, 20'hf_7fff, 20'h0_7fff, 20'hf_8000};

  sras_top #(.RAW_W(RAW_W)) u_dut (
    .mclk(mclk), .nrst(nrst), .raw_data(raw_data), .raw_valid(raw_valid), .raw_ready(raw_ready),
    .sclk(sclk), .chip_select_n(chip_select_n), .mosi(mosi), .miso(miso), .miso_oe()
  );
  sras_host u_host (.sclk(sclk), .chip_select_n(chip_select_n), .mosi(mosi), .miso(miso), .rx_q(rx_q));

  // Converter clock of 50 ns.
  initial mclk = 1'b0;
  always #25 mclk = ~mclk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected result code of a raw sample: clamped to the extremes.
  function automatic logic [15:0] clampv(input logic [RAW_W-1:0] v);
    int s;
    s = $signed(v);
    if (s > 32767) return 16'h7fff;
    if (s < -32768) return 16'h8000;
    return v[15:0];
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Notes the expected byte, then reads one.
  task automatic rd(input logic [7:0] exp);
    exp_q.push_back(exp);
    u_host.xfer(8'h00, 1'b1);
  endtask
  task automatic wr(input logic [7:0] b);
    u_host.xfer(b, 1'b0);
  endtask

  // Sets the upper register address in a frame of its own.
  task automatic set_upper(input logic [7:0] b);
    u_host.start();
    wr(INST_URA_WRITE);
    wr(b);
    u_host.stop();
  endtask

  // Offers a sample at the falling edge until it is taken.
  task automatic push(input logic [RAW_W-1:0] v);
    int n;
    @(negedge mclk);
    raw_valid = 1'b1;
    raw_data = v;
    n = 0;
    while (raw_ready !== 1'b1 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 100) check({7'h00, raw_ready}, 8'h01);
    @(negedge mclk);
    raw_valid = 1'b0;
  endtask

  // Reads both result bytes with a two-byte read at lower address 0xa.
  task automatic readres(input logic [15:0] r);
    u_host.start();
    wr(8'haa);
    rd(r[15:8]);
    rd(r[7:0]);
    u_host.stop();
  endtask
  task automatic result(input logic [RAW_W-1:0] v);
    res = clampv(v);
    push(v);
    readres(res);
  endtask

  // Compares each returned byte with the oldest note.
  always begin
    @(u_host.got);
    check(rx_q, exp_q.pop_front());
  end

  // Main sequence.
  initial begin
    nrst = 1'b0;
    raw_valid = 1'b0;
    raw_data = '0;
    lfsr_q = 32'hfe6f_5271;
    err_count = 0;
    total_checks = 0;
    repeat (3) @(negedge mclk);
    nrst = 1'b1;
    set_upper(8'hf9);
    u_host.start();
    wr(INST_URA_READ);
    rd(8'h01);
    u_host.stop();
    foreach (tbl[i]) result(tbl[i]);
    repeat (4) begin
      lfsr_q = lfsr(lfsr_q);
      result(lfsr_q[RAW_W-1:0]);
      result({{4{lfsr_q[31]}}, lfsr_q[31:16]});
    end
    // Three-byte read, then a normal stream in the same frame.
    u_host.start();
    wr(8'hca);
    rd(res[15:8]);
    rd(res[7:0]);
    rd(8'h00);
    wr(8'hfa);
    rd(res[15:8]);
    rd(res[7:0]);
    rd(8'h00);
    u_host.stop();
    set_upper(8'h00);
    u_host.start();
    wr(8'h83);
    rd(STREAM_CONTROL_RESET);
    wr(8'h22);
    wr(8'h5a);
    wr(8'hf9);
    wr(8'h83);
    rd(8'h81);
    u_host.stop();
    set_upper(8'h01);
    u_host.start();
    wr(8'hfa);
    repeat (3) begin
      rd(res[15:8]);
      rd(res[7:0]);
    end
    u_host.stop();
    // Queue fills, refuses, drains.
    // One sample waits in the crossing register, so one more than the depth fills the queue.
    for (int i = 1; i <= FIFO_DEPTH + 1; i++) push({4'h0, 16'h1111 * i[15:0]});
    @(negedge mclk);
    check({7'h00, raw_ready}, 8'h00);
    u_host.start();
    wr(8'hfa);
    repeat (6) wr(8'h00);
    u_host.stop();
    @(negedge mclk);
    check({7'h00, raw_ready}, 8'h01);
    readres(16'h5555);
    stop_test();
  end

  // Cuts a hung run short.
  initial begin
    #2_000_000;
    err_count++;
    stop_test();
  end
endmodule
